// ### rtl/ptpwm_top.sv
// Pulse train and PWM output block with an APB register slave.
//
// Operation
// - Two dedicated outputs each run on their own as a counted pulse train or as PWM.
// - A pulse train is a square wave high for half the cycle and stops after exactly the set count.
// - The pulse count takes any value from one to the full 32-bit maximum.
// - The train cycle time is 250 to 65535 microseconds or 2 to 65535 milliseconds.
// - An odd cycle time splits unevenly, the low half being one unit longer.
// - PWM keeps a fixed period and varies the high time, one time base serving both.
// - The PWM period is 250 to 65535 microseconds or 2 to 65535 milliseconds.
// - The PWM high time is zero to 65535 units of the selected time base.
// - A high time equal to the period holds the output high throughout.
// - A zero high time holds the output low throughout.
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module ptpwm_top
    import ptpwm_pkg::*;
#(
    parameter int US_DIV = US_CYCLES,
    parameter int MS_DIV = MS_US
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pulse outputs.
    output logic pulse_out_a,
    output logic pulse_out_b
);
    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] tb;
        logic [1:0][15:0] cyc;
        logic [1:0][15:0] wid;
        logic [1:0][31:0] cnt;
        logic [1:0] start;
        logic [1:0] stop;
        logic pready;
        logic pslverr;
        logic [DATA_W-1:0] prdata;
        logic out_a;
        logic out_b;
    } ptpwm_top_st_t;

    ptpwm_top_st_t q_ff;
    ptpwm_top_st_t nxt_q;

    logic tick_us;
    logic tick_ms;
    logic [1:0] busy;
    logic [1:0] level;
    logic [1:0][31:0] left;

    // Register offset inside a channel's window.
    function automatic logic [ADDR_W-1:0] reg_off(input logic [ADDR_W-1:0] a);
        reg_off = a & ~CHAN_STRIDE;
    endfunction

    // True for an address that names a register.
    function automatic logic reg_ok(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] o;
        o = reg_off(a);
        reg_ok = (o == OFF_CTRL) || (o == OFF_CYCLE) || (o == OFF_WIDTH) ||
                 (o == OFF_COUNT) || (o == OFF_STATUS) || (o == OFF_LEFT);
    endfunction

    ptpwm_tick #(
        .US_DIV(US_DIV),
        .MS_DIV(MS_DIV)
    ) u_tick (
        .clk(clk),
        .rst_b(rst_b),
        .tick_us(tick_us),
        .tick_ms(tick_ms)
    );

    ptpwm_chan_if ch_if [2] ();

    // Two identical channels, each with its own settings.
    for (genvar i = 0; i < 2; i++) begin : g_chan
        assign ch_if[i].tick_us = tick_us;
        assign ch_if[i].tick_ms = tick_ms;
        assign ch_if[i].mode = q_ff.mode[i];
        assign ch_if[i].tb = q_ff.tb[i];
        assign ch_if[i].start = q_ff.start[i];
        assign ch_if[i].stop = q_ff.stop[i];
        assign ch_if[i].cycle = q_ff.cyc[i];
        assign ch_if[i].width = q_ff.wid[i];
        assign ch_if[i].count = q_ff.cnt[i];
        assign busy[i] = ch_if[i].busy;
        assign level[i] = ch_if[i].level;
        assign left[i] = ch_if[i].left;

        ptpwm_chan u_chan (
            .clk(clk),
            .rst_b(rst_b),
            .bus(ch_if[i].chan)
        );
    end

    logic ch;
    logic [ADDR_W-1:0] off;

    always_comb begin
        nxt_q = q_ff;
        nxt_q.start = 2'b00;
        nxt_q.stop = 2'b00;
        nxt_q.pready = 1'b0;
        nxt_q.pslverr = 1'b0;
        ch = paddr[CHAN_BIT];
        off = reg_off(paddr);

        // Setup phase: decode and prepare the answer for the access phase.
        if (psel && !penable) begin
            nxt_q.pready = 1'b1;
            nxt_q.prdata = '0;
            if (!reg_ok(paddr)) begin
                nxt_q.pslverr = 1'b1;
            end else if (!pwrite) begin
                unique case (off)
                    OFF_CTRL: begin
                        nxt_q.prdata[CTRL_MODE_BIT] = q_ff.mode[ch];
                        nxt_q.prdata[CTRL_TB_BIT] = q_ff.tb[ch];
                    end
                    OFF_CYCLE: begin
                        nxt_q.prdata[15:0] = q_ff.cyc[ch];
                    end
                    OFF_WIDTH: begin
                        nxt_q.prdata[15:0] = q_ff.wid[ch];
                    end
                    OFF_COUNT: begin
                        nxt_q.prdata = q_ff.cnt[ch];
                    end
                    OFF_STATUS: begin
                        nxt_q.prdata[STAT_BUSY_BIT] = busy[ch];
                        nxt_q.prdata[STAT_LEVEL_BIT] = level[ch];
                    end
                    default: begin
                        nxt_q.prdata = left[ch];
                    end
                endcase
            end
        end

        // Access phase: a write lands on the edge that completes the transfer.
        if (psel && penable && q_ff.pready && pwrite && !q_ff.pslverr) begin
            unique case (off)
                OFF_CTRL: begin
                    nxt_q.mode[ch] = pwdata[CTRL_MODE_BIT];
                    nxt_q.tb[ch] = pwdata[CTRL_TB_BIT];
                    nxt_q.start[ch] = pwdata[CTRL_START_BIT];
                    nxt_q.stop[ch] = pwdata[CTRL_STOP_BIT];
                end
                OFF_CYCLE: begin
                    nxt_q.cyc[ch] = pwdata[15:0];
                end
                OFF_WIDTH: begin
                    nxt_q.wid[ch] = pwdata[15:0];
                end
                OFF_COUNT: begin
                    nxt_q.cnt[ch] = pwdata;
                end
                default: begin
                end
            endcase
        end

        nxt_q.out_a = level[0];
        nxt_q.out_b = level[1];
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q_ff.mode <= {CTRL_MODE_RST, CTRL_MODE_RST};
            q_ff.tb <= {CTRL_TB_RST, CTRL_TB_RST};
            q_ff.cyc <= {CYCLE_RST, CYCLE_RST};
            q_ff.wid <= {WIDTH_RST, WIDTH_RST};
            q_ff.cnt <= {COUNT_RST, COUNT_RST};
            q_ff.start <= 2'b00;
            q_ff.stop <= 2'b00;
            q_ff.pready <= 1'b0;
            q_ff.pslverr <= 1'b0;
            q_ff.prdata <= '0;
            q_ff.out_a <= 1'b0;
            q_ff.out_b <= 1'b0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign prdata = q_ff.prdata;
    assign pready = q_ff.pready;
    assign pslverr = q_ff.pslverr;
    assign pulse_out_a = q_ff.out_a;
    assign pulse_out_b = q_ff.out_b;
endmodule

// ### rtl/ptpwm_pkg.sv
// Constants, register map and reset values of the pulse train and PWM output block.
package ptpwm_pkg;
    // Bus geometry.
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Register offsets; channel b sits one stride above channel a.
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_CYCLE = 12'h004;
    localparam logic [11:0] OFF_WIDTH = 12'h008;
    localparam logic [11:0] OFF_COUNT = 12'h00c;
    localparam logic [11:0] OFF_STATUS = 12'h010;
    localparam logic [11:0] OFF_LEFT = 12'h014;
    localparam logic [11:0] CHAN_STRIDE = 12'h020;
    localparam int CHAN_BIT = 5;

    // Field positions.
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_TB_BIT = 1;
    localparam int CTRL_START_BIT = 2;
    localparam int CTRL_STOP_BIT = 3;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_LEVEL_BIT = 1;

    // Reset values.
    localparam logic CTRL_MODE_RST = 1'b0;
    localparam logic CTRL_TB_RST = 1'b0;
    localparam logic [15:0] CYCLE_RST = 16'h00fa;
    localparam logic [15:0] WIDTH_RST = 16'h0000;
    localparam logic [31:0] COUNT_RST = 32'h0000_0001;

    // Mode and time-base codes.
    localparam logic MODE_TRAIN = 1'b0;
    localparam logic MODE_PWM = 1'b1;
    localparam logic TB_US = 1'b0;
    localparam logic TB_MS = 1'b1;

    // Least cycle time in units of each time base.
    localparam logic [15:0] MIN_CYC_US = 16'h00fa;
    localparam logic [15:0] MIN_CYC_MS = 16'h0002;

    // Timing: clock period and time-base lengths, and the derived cycle count.
    localparam int CLK_PERIOD_NS = 5;
    localparam int US_NS = 1000;
    localparam int MS_US = 1000;
    localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
endpackage

// ### rtl/ptpwm_chan_if.sv
// Connection between the register block and one output channel.
`timescale 1ns/1ps
interface ptpwm_chan_if;
    logic tick_us;
    logic tick_ms;
    logic mode;
    logic tb;
    logic start;
    logic stop;
    logic [15:0] cycle;
    logic [15:0] width;
    logic [31:0] count;
    logic busy;
    logic level;
    logic [31:0] left;

    modport ctl (
        output tick_us, tick_ms, mode, tb, start, stop, cycle, width, count,
        input busy, level, left
    );
    modport chan (
        input tick_us, tick_ms, mode, tb, start, stop, cycle, width, count,
        output busy, level, left
    );
endinterface

// ### rtl/ptpwm_tick.sv
// Time-base divider: one-cycle microsecond and millisecond enable pulses.
`timescale 1ns/1ps
module ptpwm_tick
    import ptpwm_pkg::*;
#(
    parameter int US_DIV = US_CYCLES,
    parameter int MS_DIV = MS_US
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Enable pulses.
    output logic tick_us,
    output logic tick_ms
);
    typedef struct packed {
        logic [15:0] us_cnt;
        logic [15:0] ms_cnt;
        logic tick_us;
        logic tick_ms;
    } ptpwm_tick_st_t;

    ptpwm_tick_st_t q_ff;
    ptpwm_tick_st_t nxt_q;

    always_comb begin
        nxt_q = q_ff;
        nxt_q.tick_us = 1'b0;
        nxt_q.tick_ms = 1'b0;
        if (q_ff.us_cnt == 16'(US_DIV - 1)) begin
            nxt_q.us_cnt = 16'h0000;
            nxt_q.tick_us = 1'b1;
            if (q_ff.ms_cnt == 16'(MS_DIV - 1)) begin
                nxt_q.ms_cnt = 16'h0000;
                nxt_q.tick_ms = 1'b1;
            end else begin
                nxt_q.ms_cnt = q_ff.ms_cnt + 16'h0001;
            end
        end else begin
            nxt_q.us_cnt = q_ff.us_cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign tick_us = q_ff.tick_us;
    assign tick_ms = q_ff.tick_ms;
endmodule

// ### rtl/ptpwm_chan.sv
// One output channel: counted square-wave train or fixed-period PWM.
`timescale 1ns/1ps
module ptpwm_chan
    import ptpwm_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Settings and state.
    ptpwm_chan_if.chan bus
);
    typedef struct packed {
        logic run;
        logic mode;
        logic tb;
        logic [15:0] per;
        logic [15:0] hi;
        logic [15:0] phase;
        logic [31:0] left;
        logic out;
    } ptpwm_chan_st_t;

    ptpwm_chan_st_t q_ff;
    ptpwm_chan_st_t nxt_q;

    // Period in time-base units, raised to the least legal value.
    function automatic logic [15:0] per_of(input logic tb, input logic [15:0] cyc);
        logic [15:0] lo;
        lo = (tb == TB_MS) ? MIN_CYC_MS : MIN_CYC_US;
        per_of = (cyc < lo) ? lo : cyc;
    endfunction

    // High time: half the period for a train, the width capped at the period for PWM.
    function automatic logic [15:0] hi_of(input logic mode, input logic [15:0] per, input logic [15:0] wid);
        if (mode == MODE_PWM) begin
            hi_of = (wid > per) ? per : wid;
        end else begin
            hi_of = {1'b0, per[15:1]};
        end
    endfunction

    logic tick;
    logic [15:0] new_per;
    logic [15:0] new_hi;

    always_comb begin
        nxt_q = q_ff;
        tick = (q_ff.tb == TB_MS) ? bus.tick_ms : bus.tick_us;
        new_per = per_of(bus.tb, bus.cycle);
        new_hi = hi_of(bus.mode, new_per, bus.width);
        if (bus.stop) begin
            nxt_q.run = 1'b0;
            nxt_q.out = 1'b0;
            nxt_q.left = 32'h0000_0000;
        end else if (bus.start && !q_ff.run) begin
            nxt_q.mode = bus.mode;
            nxt_q.tb = bus.tb;
            nxt_q.per = new_per;
            nxt_q.hi = new_hi;
            nxt_q.phase = 16'h0000;
            nxt_q.left = (bus.count == 32'h0000_0000) ? 32'h0000_0001 : bus.count;
            nxt_q.run = 1'b1;
            nxt_q.out = (new_hi != 16'h0000);
        end else if (q_ff.run && tick) begin
            if (q_ff.phase == q_ff.per - 16'h0001) begin
                nxt_q.phase = 16'h0000;
                if (q_ff.mode == MODE_TRAIN) begin
                    if (q_ff.left == 32'h0000_0001) begin
                        nxt_q.run = 1'b0;
                        nxt_q.out = 1'b0;
                        nxt_q.left = 32'h0000_0000;
                    end else begin
                        nxt_q.left = q_ff.left - 32'h0000_0001;
                        nxt_q.out = (q_ff.hi != 16'h0000);
                    end
                end else begin
                    // New PWM settings take effect at the period boundary only.
                    nxt_q.per = per_of(q_ff.tb, bus.cycle);
                    nxt_q.hi = hi_of(MODE_PWM, per_of(q_ff.tb, bus.cycle), bus.width);
                    nxt_q.out = (hi_of(MODE_PWM, per_of(q_ff.tb, bus.cycle), bus.width) != 16'h0000);
                end
            end else begin
                nxt_q.phase = q_ff.phase + 16'h0001;
                // A high time equal to the period never drops here, a zero one never rises.
                nxt_q.out = ({1'b0, q_ff.phase} + 17'h00001) < {1'b0, q_ff.hi};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign bus.busy = q_ff.run;
    assign bus.level = q_ff.out;
    assign bus.left = q_ff.left;
endmodule

// ### dv/ptpwm_properties.sv
// Assertion checker for the pulse train and PWM block, bound to its top module.
`timescale 1ns/1ps
module ptpwm_properties
    import ptpwm_pkg::*;
#(
    parameter int US_DIV = US_CYCLES,
    parameter int MS_DIV = MS_US
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pulse outputs.
    input wire logic pulse_out_a,
    input wire logic pulse_out_b
);
    logic [15:0] cyc_ff;
    logic [15:0] wid_ff;
    logic wr;
    logic go_a;
    logic pwm_go;
    assign wr = psel && penable && pready && pwrite;
    assign go_a = wr && paddr == OFF_CTRL && pwdata[CTRL_START_BIT];
    assign pwm_go = go_a && pwdata[CTRL_MODE_BIT] == MODE_PWM && pwdata[CTRL_TB_BIT] == TB_MS;
    // Shadow of channel a settings, so the PWM limits can be predicted.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cyc_ff <= CYCLE_RST;
            wid_ff <= WIDTH_RST;
        end else if (wr && paddr == OFF_CYCLE) begin
            cyc_ff <= pwdata[15:0];
        end else if (wr && paddr == OFF_WIDTH) begin
            wid_ff <= pwdata[15:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_ready;
        psel && !penable |=> pready;
    endproperty
    property p_ready_once;
        pready |=> !pready;
    endproperty
    property p_err_zero;
        pready && pslverr |-> prdata == '0;
    endproperty
    property p_rst_low;
        $rose(rst_b) |-> !pulse_out_a && !pulse_out_b;
    endproperty
    property p_train_go;
        go_a && pwdata[CTRL_MODE_BIT] == MODE_TRAIN |-> ##[3:4] pulse_out_a;
    endproperty
    property p_pwm_zero;
        pwm_go && wid_ff == 16'h0 |-> ##2 !pulse_out_a [*8];
    endproperty
    property p_pwm_full;
        pwm_go && wid_ff >= cyc_ff && cyc_ff >= MIN_CYC_MS |-> ##4 pulse_out_a [*8];
    endproperty
    property p_stop_low;
        wr && paddr == OFF_CTRL && pwdata[CTRL_STOP_BIT] |-> ##4 !pulse_out_a;
    endproperty
    a_ready: assert property (p_ready) else $error("pready missing after setup");
    a_ready_once: assert property (p_ready_once) else $error("pready held too long");
    a_err_zero: assert property (p_err_zero) else $error("error read data not zero");
    a_rst_low: assert property (p_rst_low) else $error("output high after reset");
    a_train_go: assert property (p_train_go) else $error("train did not start high");
    a_pwm_zero: assert property (p_pwm_zero) else $error("zero width not low");
    a_pwm_full: assert property (p_pwm_full) else $error("full width not high");
    a_stop_low: assert property (p_stop_low) else $error("output high after stop");
    c_train: cover property (go_a ##4 pulse_out_a);
    c_err: cover property (pready && pslverr);
    c_fall_b: cover property ($fell(pulse_out_b));
endmodule
bind ptpwm_top ptpwm_properties #(.US_DIV(US_DIV), .MS_DIV(MS_DIV)) u_props (.*);

// ### dv/ptpwm_drive.sv
// Model of the driven actuator: counts pulses and times the last high and low runs.
`timescale 1ns/1ps
module ptpwm_drive (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Observed line and counter clear.
    input wire logic pulse_in,
    input wire logic clear,
    // Measurements: rising-edge count, and high and low run lengths in clock cycles.
    output logic [31:0] n_rise,
    output logic [31:0] hi_len,
    output logic [31:0] lo_len
);
    logic [31:0] run_ff;
    logic last_ff;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            n_rise <= 32'h0;
            hi_len <= 32'h0;
            lo_len <= 32'h0;
            run_ff <= 32'h1;
            last_ff <= 1'b0;
        end else begin
            last_ff <= pulse_in;
            if (clear) begin
                n_rise <= 32'h0;
                run_ff <= 32'h1;
            end else if (pulse_in != last_ff) begin
                run_ff <= 32'h1;
                if (last_ff) begin
                    hi_len <= run_ff;
                end else begin
                    lo_len <= run_ff;
                end
                if (pulse_in) begin
                    n_rise <= n_rise + 32'h1;
                end
            end else begin
                run_ff <= run_ff + 32'h1;
            end
        end
    end
endmodule

// ### dv/ptpwm_bench.sv
// Self-checking bench for the pulse train and PWM block.
`timescale 1ns/1ps
module ptpwm_bench
    import ptpwm_pkg::*;
;
    localparam logic [31:0] GO = 32'h1 << CTRL_START_BIT;
    localparam logic [31:0] MS = 32'h1 << CTRL_TB_BIT;
    localparam logic [31:0] PWM = 32'h1 << CTRL_MODE_BIT;
    localparam logic [31:0] HALT = 32'h1 << CTRL_STOP_BIT;
    localparam logic [11:0] CHB = CHAN_STRIDE;
    localparam logic [31:0] U = 32'h2;
    localparam logic [31:0] MSC = 32'h8;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pulse_out_a;
    logic pulse_out_b;
    logic clr = 1'b0;
    logic [31:0] na, ha, la, nb, hb, lb;
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    ptpwm_top #(.US_DIV(2), .MS_DIV(4)) u_dut (.*);
    ptpwm_drive u_drv_a (.clk(clk), .rst_b(rst_b), .pulse_in(pulse_out_a), .clear(clr),
        .n_rise(na), .hi_len(ha), .lo_len(la));
    ptpwm_drive u_drv_b (.clk(clk), .rst_b(rst_b), .pulse_in(pulse_out_b), .clear(clr),
        .n_rise(nb), .hi_len(hb), .lo_len(lb));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic end_of_test();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic chk(input string s, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", s, exp, got);
        end
    endtask
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        xfer(a, 1'b1, d, q, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string s);
        logic [31:0] q;
        logic e;
        xfer(a, 1'b0, 32'h0, q, e);
        chk(s, exp, q);
    endtask
    task automatic idle(input logic [11:0] base);
        logic [31:0] q;
        logic e;
        q = 32'h1;
        while (q[STAT_BUSY_BIT] !== 1'b0)
            xfer(base + OFF_STATUS, 1'b0, 32'h0, q, e);
    endtask
    task automatic clear();
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
    endtask
    initial begin
        logic [31:0] q;
        logic e;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(OFF_CTRL, 32'h0, "ctrl_a");
        rd(CHB + OFF_CYCLE, {16'h0, CYCLE_RST}, "cycle_b");
        rd(OFF_WIDTH, {16'h0, WIDTH_RST}, "width_a");
        rd(CHB + OFF_COUNT, COUNT_RST, "count_b");
        wr(OFF_COUNT, 32'hffff_ffff);
        rd(OFF_COUNT, 32'hffff_ffff, "count_max");
        xfer(12'h01c, 1'b0, 32'h0, q, e);
        chk("unmapped_err", 32'h1, {31'h0, e});
        chk("unmapped_data", 32'h0, q);
        $display("test registers done");
        wr(OFF_CYCLE, 32'h4);
        wr(OFF_COUNT, 32'h3);
        wr(CHB + OFF_CYCLE, 32'h3);
        wr(CHB + OFF_COUNT, 32'h2);
        clear();
        wr(OFF_CTRL, GO | MS);
        wr(CHB + OFF_CTRL, GO | MS);
        idle(12'h000);
        idle(CHB);
        repeat (40) @(posedge clk);
        chk("pulses_a", 32'h3, na);
        chk("high_a", 2 * MSC, ha);
        chk("low_a", 2 * MSC, la);
        chk("pulses_b", 32'h2, nb);
        chk("high_b", MSC, hb);
        chk("low_b", 2 * MSC, lb);
        chk("idle_a", 32'h0, {31'h0, pulse_out_a});
        chk("idle_b", 32'h0, {31'h0, pulse_out_b});
        rd(OFF_LEFT, 32'h0, "left_a");
        $display("test ms trains done");
        wr(OFF_CYCLE, {16'h0, MIN_CYC_US});
        wr(OFF_COUNT, 32'h2);
        clear();
        wr(OFF_CTRL, GO);
        idle(12'h000);
        chk("pulses_us", 32'h2, na);
        chk("high_us", 32'h7d * U, ha);
        chk("low_us", 32'h7d * U, la);
        $display("test us train done");
        wr(OFF_CYCLE, 32'h4);
        wr(OFF_WIDTH, 32'h1);
        wr(OFF_CTRL, GO | MS | PWM);
        repeat (160) @(posedge clk);
        chk("pwm_high", MSC, ha);
        chk("pwm_low", 3 * MSC, la);
        wr(OFF_CTRL, HALT);
        wr(OFF_WIDTH, 32'h4);
        clear();
        wr(OFF_CTRL, GO | MS | PWM);
        repeat (64) @(posedge clk);
        chk("full_rises", 32'h1, na);
        chk("full_level", 32'h1, {31'h0, pulse_out_a});
        wr(OFF_CTRL, HALT);
        wr(OFF_WIDTH, 32'h0);
        clear();
        wr(OFF_CTRL, GO | MS | PWM);
        repeat (64) @(posedge clk);
        chk("zero_rises", 32'h0, na);
        chk("zero_level", 32'h0, {31'h0, pulse_out_a});
        wr(OFF_CTRL, HALT);
        rd(OFF_STATUS, 32'h0, "status_stop");
        $display("test pwm done");
        wr(OFF_COUNT, 32'h0);
        wr(CHB + OFF_CYCLE, 32'h1);
        clear();
        wr(OFF_CTRL, GO | MS);
        wr(CHB + OFF_CTRL, GO | MS);
        idle(12'h000);
        idle(CHB);
        repeat (8) @(posedge clk);
        chk("pulses_count_zero", 32'h1, na);
        chk("pulses_min_b", 32'h2, nb);
        chk("high_min_b", MSC, hb);
        chk("low_min_b", MSC, lb);
        wr(OFF_COUNT, 32'h5);
        clear();
        wr(OFF_CTRL, GO | MS);
        wr(OFF_CTRL, GO | PWM);
        rd(OFF_LEFT, 32'h5, "left_busy");
        idle(12'h000);
        chk("pulses_busy", 32'h5, na);
        $display("test limits done");
        wr(CHB + OFF_CYCLE, 32'ha);
        wr(CHB + OFF_WIDTH, 32'h32);
        wr(CHB + OFF_CTRL, GO | PWM);
        repeat (1100) @(posedge clk);
        chk("pwm_us_high", 32'h32 * U, hb);
        chk("pwm_us_low", ({16'h0, MIN_CYC_US} - 32'h32) * U, lb);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(CHB + OFF_CYCLE, {16'h0, CYCLE_RST}, "cycle_after_reset");
        chk("out_after_reset", 32'h0, {31'h0, pulse_out_b});
        $display("test us pwm and reset done");
        end_of_test();
    end
endmodule
